//--- core/dbcsc_consts.svh
// Constants shared by both ends of the burst-of-four common-I/O SRAM link.
// Assumes one 50 MHz system clock; each K half-period is one system cycle.
`ifndef DBCSC_CONSTS_SVH
`define DBCSC_CONSTS_SVH
`define DBCSC_CLK_NS 20
`define DBCSC_STOP_NS 30
`define DBCSC_STOP_CYC ((`DBCSC_STOP_NS / `DBCSC_CLK_NS) + 1)
`define DBCSC_LOCK_KCYC 2048
`define DBCSC_BURST 4
`define DBCSC_RL_HALF 4
`define DBCSC_RL_OFF_HALF 2
`define DBCSC_WL_HALF 10
`define DBCSC_TERM_TAIL_HALF 1
`define DBCSC_DLL_RST_CYC 4
`define DBCSC_PIPE 13
`define DBCSC_OFF_CTRL 8'h00
`define DBCSC_OFF_ADDR 8'h04
`define DBCSC_OFF_STAT 8'h08
`define DBCSC_OFF_WDAT 8'h10
`define DBCSC_OFF_RDAT 8'h20
`define DBCSC_BIT_START 0
`define DBCSC_BIT_WRITE 1
`define DBCSC_BIT_DLLRST 2
`define DBCSC_BIT_BYPASS 3
`define DBCSC_BIT_STOP 4
`define DBCSC_BIT_ODTDRV 5
`define DBCSC_BIT_ODTHI 6
`endif

//--- core/dbcsc_pkg.sv
// Types shared by the SRAM device model and its controller.
// Assumes the constants header is on the include path.
`default_nettype none
package dbcsc_pkg;
    typedef enum logic [0:0] {DBCSC_LOCKING = 1'h0, DBCSC_READY = 1'h1} dbcsc_dll_t;
    typedef enum logic [1:0] {DBCSC_TERM_LOW = 2'h0, DBCSC_TERM_HIGH = 2'h1,
        DBCSC_TERM_FLOAT = 2'h2} dbcsc_term_t;
    typedef enum logic [1:0] {DBCSC_C_DLLRST = 2'h0, DBCSC_C_LOCK = 2'h1,
        DBCSC_C_IDLE = 2'h2, DBCSC_C_XFER = 2'h3} dbcsc_ctl_st_t;
endpackage
`default_nettype wire

//--- core/dbcsc_if.sv
// Board-level link between the SRAM and its controller.
// Resolves the shared data bus; the termination pin is carried as a level and an enable.
`default_nettype none
interface dbcsc_if #(parameter int DW = 18, parameter int AW = 4, parameter int BW = 2);
    logic kClk;
    logic kClkN;
    logic loadStrobeN;
    logic rwN;
    logic [AW-1:0] addr;
    logic [BW-1:0] byteWriteN;
    logic dllOffN;
    logic odtOut;
    logic odtOe;
    logic [DW-1:0] dqCtl;
    logic dqCtlOe;
    logic [DW-1:0] dqDev;
    logic dqDevOe;
    wire logic [DW-1:0] dq;
    // A released bus shows the inverse of the last controller word, so a sample taken there is caught
    assign dq = dqDevOe ? dqDev : (dqCtlOe ? dqCtl : ~dqCtl);
    modport dev (input kClk, kClkN, loadStrobeN, rwN, addr, byteWriteN, dllOffN, odtOut, odtOe, dq,
        output dqDev, dqDevOe);
    modport ctl (output kClk, kClkN, loadStrobeN, rwN, addr, byteWriteN, dllOffN, odtOut, odtOe,
        dqCtl, dqCtlOe, input dq);
endinterface
`default_nettype wire

//--- core/dbcsc_device.sv
// Burst-of-four common-I/O DDR SRAM: command decode, DLL lock, data slots, termination.
// Assumes K/K# arrive as levels sampled on clk_sys, one K half-period per cycle.
`include "dbcsc_consts.svh"
`default_nettype none
module dbcsc_device #(
    parameter int DW = 18,
    parameter int AW = 4,
    parameter int BW = 2,
    parameter int ODT_OPTION = 1,
    parameter int LOCK_KCYC = `DBCSC_LOCK_KCYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, low
    dbcsc_if.dev link, // Pins facing the controller
    output logic termClkOn, // Clock pair terminated
    output logic termDataOn, // Data lines terminated
    output logic termBwOn, // Byte-write inputs terminated
    output dbcsc_pkg::dbcsc_term_t termLevel, // Setting picked by the pin
    output logic dllReady // Lock period over
);
    import dbcsc_pkg::*;

    localparam int PIPE = `DBCSC_PIPE;
    localparam int DEPTH = 1 << AW;
    localparam int BYTEW = DW / BW;

    typedef struct packed {
        logic kPrev;
        logic dllPrev;
        logic [1:0] stillCnt;
        logic [11:0] lockCnt;
        dbcsc_dll_t dll;
        logic [PIPE-1:0] pv;
        logic [PIPE-1:0] pw;
        logic [PIPE-1:0][AW-1:0] pa;
        logic [DW-1:0] dq;
        logic oe;
        logic [DEPTH-1:0][DW-1:0] mem;
    } dbcsc_dev_st_t;

    dbcsc_dev_st_t st_reg;
    dbcsc_dev_st_t st_next;
    logic kEdge;
    logic kRise;
    logic dllReset;
    logic readNear;
    int lat;

    always_comb
    begin
        st_next = st_reg;
        kEdge = link.kClk != st_reg.kPrev;
        kRise = kEdge && link.kClk;
        lat = link.dllOffN ? `DBCSC_RL_HALF : `DBCSC_RL_OFF_HALF;
        st_next.kPrev = link.kClk;
        st_next.dllPrev = link.dllOffN;
        if (kEdge)
        begin
            st_next.stillCnt = 2'h0;
        end
        else if (st_reg.stillCnt != 2'(`DBCSC_STOP_CYC))
        begin
            st_next.stillCnt = st_reg.stillCnt + 2'h1;
        end
        // Static clock counts once, so a long stop gives a single DLL reset
        dllReset = (st_next.stillCnt == 2'(`DBCSC_STOP_CYC) && st_reg.stillCnt != 2'(`DBCSC_STOP_CYC))
            || (link.dllOffN && !st_reg.dllPrev);
        if (dllReset)
        begin
            st_next.lockCnt = 12'h000;
            st_next.dll = DBCSC_LOCKING;
        end
        else if (kRise && st_reg.dll == DBCSC_LOCKING)
        begin
            // Same count with the DLL bypassed; only the lock itself is skipped
            if (st_reg.lockCnt == 12'(LOCK_KCYC - 1))
            begin
                st_next.dll = DBCSC_READY;
            end
            else
            begin
                st_next.lockCnt = st_reg.lockCnt + 12'h001;
            end
        end
        // Nothing moves between K edges, so a stopped clock holds the bus
        if (kEdge)
        begin
            st_next.pv = {st_reg.pv[PIPE-2:0], kRise && !link.loadStrobeN && st_reg.dll == DBCSC_READY};
            st_next.pw = {st_reg.pw[PIPE-2:0], !link.rwN};
            st_next.pa = {st_reg.pa[PIPE-2:0], link.addr};
            st_next.oe = 1'b0;
            for (int i = 0; i < `DBCSC_BURST; i++)
            begin
                if (st_reg.pv[lat - 2 + i] && !st_reg.pw[lat - 2 + i])
                begin
                    st_next.dq = st_reg.mem[st_reg.pa[lat - 2 + i] + AW'(i)];
                    st_next.oe = 1'b1;
                end
                if (st_reg.pv[`DBCSC_WL_HALF - 1 + i] && st_reg.pw[`DBCSC_WL_HALF - 1 + i])
                begin
                    for (int b = 0; b < BW; b++)
                    begin
                        if (!link.byteWriteN[b])
                        begin
                            st_next.mem[st_reg.pa[`DBCSC_WL_HALF - 1 + i] + AW'(i)][b*BYTEW +: BYTEW] =
                                link.dq[b*BYTEW +: BYTEW];
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Read window spans latency minus half a cycle to burst end plus half
    always_comb
    begin
        readNear = 1'b0;
        for (int k = 0; k < PIPE; k++)
        begin
            if (k >= lat - 2 && k <= lat + `DBCSC_BURST - 2 + `DBCSC_TERM_TAIL_HALF
                && st_reg.pv[k] && !st_reg.pw[k])
            begin
                readNear = 1'b1;
            end
        end
    end

    assign termDataOn = (ODT_OPTION != 0) && !readNear;
    assign termClkOn = (ODT_OPTION == 1);
    assign termBwOn = (ODT_OPTION != 0);
    assign termLevel = !link.odtOe ? DBCSC_TERM_FLOAT : (link.odtOut ? DBCSC_TERM_HIGH : DBCSC_TERM_LOW);
    assign dllReady = st_reg.dll == DBCSC_READY;
    assign link.dqDev = st_reg.dq;
    assign link.dqDevOe = st_reg.oe;
endmodule // dbcsc_device
`default_nettype wire

//--- core/dbcsc_ctrl.sv
// Memory controller for the burst-of-four SRAM, ordered through APB registers.
// Assumes a zero-wait APB master on clk_sys; K is made here at half clk_sys.
`include "dbcsc_consts.svh"
`default_nettype none
module dbcsc_ctrl #(
    parameter int DW = 18,
    parameter int AW = 4,
    parameter int BW = 2,
    parameter int LOCK_KCYC = `DBCSC_LOCK_KCYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped
    output dbcsc_pkg::dbcsc_ctl_st_t ctlState, // Sequencer state
    dbcsc_if.ctl link // Pins facing the SRAM
);
    import dbcsc_pkg::*;

    typedef struct packed {
        dbcsc_ctl_st_t st;
        logic [12:0] cnt;
        logic [1:0] stillCnt;
        logic kClk;
        logic ld;
        logic rw;
        logic [AW-1:0] aOut;
        logic [BW-1:0] bw;
        logic [DW-1:0] dq;
        logic dqOe;
        logic dllOffN;
        logic [6:0] ctrl;
        logic [AW-1:0] addr;
        logic [3:0][BW+DW-1:0] wdat;
        logic [3:0][DW-1:0] rdat;
    } dbcsc_ctl_st_s_t;

    dbcsc_ctl_st_s_t st_reg;
    dbcsc_ctl_st_s_t st_next;
    logic access;
    logic hit;
    logic run;
    logic [12:0] lat;
    logic [12:0] wi;

    assign access = psel && penable;
    assign pready = 1'b1;
    assign hit = paddr[7:6] == 2'h0 && paddr[1:0] == 2'h0
        && (paddr < `DBCSC_OFF_STAT + 8'h04 || paddr[7:4] == 4'h1 || paddr[7:4] == 4'h2);
    assign pslverr = access && !hit;

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (paddr == `DBCSC_OFF_CTRL)
        begin
            prdata = 32'(st_reg.ctrl);
        end
        else if (paddr == `DBCSC_OFF_ADDR)
        begin
            prdata = 32'(st_reg.addr);
        end
        else if (paddr == `DBCSC_OFF_STAT)
        begin
            prdata = {28'h000_0000, st_reg.stillCnt == 2'(`DBCSC_STOP_CYC),
                st_reg.st == DBCSC_C_XFER, st_reg.st == DBCSC_C_IDLE, st_reg.st == DBCSC_C_XFER};
        end
        else if (paddr[7:4] == 4'h1)
        begin
            prdata = 32'(st_reg.wdat[paddr[3:2]]);
        end
        else if (paddr[7:4] == 4'h2)
        begin
            prdata = 32'(st_reg.rdat[paddr[3:2]]);
        end
    end

    always_comb
    begin
        st_next = st_reg;
        lat = st_reg.ctrl[`DBCSC_BIT_BYPASS] ? 13'(`DBCSC_RL_OFF_HALF) : 13'(`DBCSC_RL_HALF);
        wi = st_reg.cnt + 13'h0001 - 13'(`DBCSC_WL_HALF);
        // Only a transfer overrides a stop request: none is cut short, and a relock cannot restart K
        run = !st_reg.ctrl[`DBCSC_BIT_STOP] || st_reg.st == DBCSC_C_XFER;
        st_next.ld = 1'b1;
        if (run)
        begin
            st_next.kClk = !st_reg.kClk;
            st_next.stillCnt = 2'h0;
        end
        else if (st_reg.stillCnt != 2'(`DBCSC_STOP_CYC))
        begin
            st_next.stillCnt = st_reg.stillCnt + 2'h1;
            if (st_next.stillCnt == 2'(`DBCSC_STOP_CYC))
            begin
                st_next.st = DBCSC_C_LOCK;
                st_next.cnt = 13'h0000;
            end
        end
        unique case (st_reg.st)
            DBCSC_C_DLLRST:
            begin
                // Pin held low, then raised (kept low when bypass is set) on a running clock to force relock
                st_next.dllOffN = 1'b0;
                st_next.cnt = st_reg.cnt + 13'h0001;
                if (st_reg.cnt == 13'(`DBCSC_DLL_RST_CYC - 1))
                begin
                    st_next.dllOffN = !st_reg.ctrl[`DBCSC_BIT_BYPASS];
                    st_next.st = DBCSC_C_LOCK;
                    st_next.cnt = 13'h0000;
                end
            end
            DBCSC_C_LOCK:
            begin
                if (run && !st_reg.kClk)
                begin
                    st_next.cnt = st_reg.cnt + 13'h0001;
                    if (st_reg.cnt == 13'(LOCK_KCYC))
                    begin
                        st_next.st = DBCSC_C_IDLE;
                    end
                end
            end
            DBCSC_C_IDLE:
            begin
                if (run && !st_reg.kClk && st_reg.ctrl[`DBCSC_BIT_START])
                begin
                    st_next.ld = 1'b0;
                    st_next.rw = !st_reg.ctrl[`DBCSC_BIT_WRITE];
                    st_next.aOut = st_reg.addr;
                    st_next.ctrl[`DBCSC_BIT_START] = 1'b0;
                    st_next.st = DBCSC_C_XFER;
                    st_next.cnt = 13'h0000;
                end
            end
            DBCSC_C_XFER:
            begin
                st_next.cnt = st_reg.cnt + 13'h0001;
                // Bus is released until the slot of the first word
                st_next.dqOe = !st_reg.rw && wi < 13'(`DBCSC_BURST);
                if (st_next.dqOe)
                begin
                    st_next.dq = st_reg.wdat[wi[1:0]][DW-1:0];
                    st_next.bw = st_reg.wdat[wi[1:0]][BW+DW-1:DW];
                end
                for (int i = 0; i < `DBCSC_BURST; i++)
                begin
                    if (st_reg.rw && st_reg.cnt == lat + 13'(i))
                    begin
                        st_next.rdat[i] = link.dq;
                    end
                end
                if ((st_reg.rw && st_reg.cnt == lat + 13'(`DBCSC_BURST - 1))
                    || (!st_reg.rw && st_reg.cnt == 13'(`DBCSC_WL_HALF + `DBCSC_BURST - 1)))
                begin
                    st_next.st = DBCSC_C_IDLE;
                    st_next.bw = {BW{1'b1}};
                end
            end
        endcase
        if (access && pwrite && hit)
        begin
            if (paddr == `DBCSC_OFF_CTRL)
            begin
                st_next.ctrl = pwdata[6:0];
                if (pwdata[`DBCSC_BIT_DLLRST] || pwdata[`DBCSC_BIT_BYPASS] != st_reg.ctrl[`DBCSC_BIT_BYPASS])
                begin
                    st_next.st = DBCSC_C_DLLRST;
                    st_next.cnt = 13'h0000;
                end
                st_next.ctrl[`DBCSC_BIT_DLLRST] = 1'b0;
            end
            else if (paddr == `DBCSC_OFF_ADDR)
            begin
                st_next.addr = pwdata[AW-1:0];
            end
            else if (paddr[7:4] == 4'h1)
            begin
                st_next.wdat[paddr[3:2]] = pwdata[BW+DW-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.ld <= 1'b1;
            st_reg.rw <= 1'b1;
            st_reg.bw <= {BW{1'b1}};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign ctlState = st_reg.st;
    assign link.kClk = st_reg.kClk;
    assign link.kClkN = !st_reg.kClk;
    assign link.loadStrobeN = st_reg.ld;
    assign link.rwN = st_reg.rw;
    assign link.addr = st_reg.aOut;
    assign link.byteWriteN = st_reg.bw;
    assign link.dllOffN = st_reg.dllOffN;
    assign link.odtOe = st_reg.ctrl[`DBCSC_BIT_ODTDRV];
    assign link.odtOut = st_reg.ctrl[`DBCSC_BIT_ODTHI];
    assign link.dqCtl = st_reg.dq;
    assign link.dqCtlOe = st_reg.dqOe;
endmodule // dbcsc_ctrl
`default_nettype wire

//--- verification/dbcsc_monitor.sv
// Concurrent checks on the link between the SRAM device and its controller.
// Assumes the bench instantiates it beside the link and feeds it the link signals.
`default_nettype none
module dbcsc_monitor (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, low
    input wire logic kClk, // K level
    input wire logic loadStrobeN, // Command strobe
    input wire logic rwN, // High reads
    input wire logic dllOffN, // Low bypasses DLL
    input wire logic dqDevOe, // Device drives bus
    input wire logic dqCtlOe, // Controller drives bus
    input wire logic termDataOn, // Data termination
    input wire logic dllReady // Device lock over
);
    typedef struct packed {logic kPrev; logic [3:0] sinceRd;} dbcsc_mon_t;
    dbcsc_mon_t st_reg;
    dbcsc_mon_t st_next;
    logic rdCmd;
    assign rdCmd = kClk & ~st_reg.kPrev & ~loadStrobeN & rwN & dllReady;
    // Cycles since the last read command, saturating so an idle bus reads as far away
    always_comb
    begin
        st_next.kPrev = kClk;
        st_next.sinceRd = rdCmd ? 4'h1 : ((st_reg.sinceRd == 4'hF) ? 4'hF : st_reg.sinceRd + 4'h1);
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= {1'b0, 4'hF};
        else
            st_reg <= st_next;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence rd_cmd; $rose(kClk) && !loadStrobeN && rwN && dllReady; endsequence
    sequence wr_cmd; $rose(kClk) && !loadStrobeN && !rwN && dllReady; endsequence
    sequence rd_burst; dqDevOe [*4] ##1 !dqDevOe; endsequence
    read_slots_a: assert property (rd_cmd ##0 dllOffN |-> ##4 rd_burst)
        else $error("read burst outside its slots");
    bypass_lat_a: assert property (rd_cmd ##0 !dllOffN |-> ##2 rd_burst)
        else $error("bypass read latency wrong");
    term_read_a: assert property (rd_cmd ##0 dllOffN |-> ##3 !termDataOn [*6] ##1 termDataOn)
        else $error("data termination window wrong");
    term_write_a: assert property (dqCtlOe |-> termDataOn)
        else $error("termination off during write data");
    write_slots_a: assert property (wr_cmd |-> ##10 dqCtlOe [*4] ##1 !dqCtlOe)
        else $error("write data outside its slots");
    bus_turn_a: assert property ($rose(dqCtlOe) |-> !dqDevOe && !$past(dqDevOe))
        else $error("bus not released before write data");
    idle_hiz_a: assert property (dqDevOe |-> st_reg.sinceRd inside {[4'h2:4'h7]})
        else $error("device drives bus outside a read");
    ready_first_a: assert property (!loadStrobeN |-> dllReady)
        else $error("command before lock period");
    dll_reset_a: assert property ($rose(dllOffN) |=> !dllReady [*8])
        else $error("ready too soon after DLL reset");
    k_stop_a: assert property ($stable(kClk) [*2] |-> ##[0:2] !dllReady)
        else $error("stopped clock did not reset DLL");
endmodule // dbcsc_monitor
`default_nettype wire

//--- verification/tb.sv
// Bench: controller and SRAM joined by the link, driven over APB with random data.
// Assumes the core header, package and link interface are compiled first.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic termDataOn;
    logic termClkOn;
    logic termBwOn;
    logic dllReady;
    dbcsc_pkg::dbcsc_term_t termLevel;
    dbcsc_pkg::dbcsc_ctl_st_t ctlState;
    logic [32:0] expQ[$];
    logic [17:0] mem [16];
    logic [31:0] ctrlBase = 32'h0;
    int failCount = 0;
    int nCompared = 0;
    int cyc = 0;
    always #10 clk_sys = ~clk_sys;
    dbcsc_if lnk ();
    // Short lock count keeps every relock to a few dozen cycles
    dbcsc_ctrl #(.LOCK_KCYC(8)) dbcsc_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctlState(ctlState), .link(lnk));
    dbcsc_device #(.ODT_OPTION(1), .LOCK_KCYC(8)) dbcsc_device_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .link(lnk), .termClkOn(termClkOn), .termDataOn(termDataOn), .termBwOn(termBwOn), .termLevel(termLevel),
        .dllReady(dllReady));
    dbcsc_monitor dbcsc_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n), .kClk(lnk.kClk),
        .loadStrobeN(lnk.loadStrobeN), .rwN(lnk.rwN), .dllOffN(lnk.dllOffN), .dqDevOe(lnk.dqDevOe),
        .dqCtlOe(lnk.dqCtlOe), .termDataOn(termDataOn), .dllReady(dllReady));
    task automatic fail(input string msg);
        failCount++;
        $display("CHECK FAILED t=%0t %s", $time, msg);
    endtask
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected read value is noted before the transfer; the watcher below compares it
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Issue waits for a low K, so the state may leave idle only two edges after the order lands
    task automatic wait_idle;
        repeat (3) @(posedge clk_sys);
        while (ctlState !== dbcsc_pkg::DBCSC_C_IDLE)
            @(posedge clk_sys);
    endtask
    task automatic set_ctrl(input logic [31:0] v);
        // Start and DLL reset are pulses; carrying them into later bursts would relock again
        ctrlBase = v & 32'hFFFF_FFFA;
        apb(1'b1, 8'h00, v);
        wait_idle();
    endtask
    task automatic chk_term(input dbcsc_pkg::dbcsc_term_t e);
        nCompared++;
        if (termLevel !== e) fail("termination level");
        nCompared++;
        if (termClkOn !== 1'b1 || termBwOn !== 1'b1) fail("option one coverage");
    endtask
    task automatic burst(input logic [3:0] a, input logic wr, input logic full);
        logic [17:0] w;
        logic [1:0] b;
        logic [3:0] k;
        for (int i = 0; i < 4; i++)
        begin
            k = a + 4'(i);
            w = 18'($urandom);
            b = full ? 2'h0 : 2'($urandom);
            if (wr)
            begin
                apb(1'b1, 8'(8'h10 + 4 * i), {12'h0, b, w});
                if (!b[0]) mem[k][8:0] = w[8:0];
                if (!b[1]) mem[k][17:9] = w[17:9];
            end
        end
        apb(1'b1, 8'h04, {28'h0, a});
        apb(1'b1, 8'h00, ctrlBase | (wr ? 32'h3 : 32'h1));
        wait_idle();
        if (!wr)
            for (int i = 0; i < 4; i++)
                rd(8'(8'h20 + 4 * i), {15'h0, mem[a + 4'(i)]});
    endtask
    always @(posedge clk_sys)
        if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
        begin
            nCompared++;
            if ({pslverr, prdata} !== expQ.pop_front()) fail("read data");
        end
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            fail("timeout");
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(32'hEEA8));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_idle();
        rd(8'h08, 33'h0_0000_0002);
        rd(8'h3C, {1'b1, 32'h0});
        apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        for (int a = 0; a < 16; a += 4)
            burst(4'(a), 1'b1, 1'b1);
        burst(4'hE, 1'b0, 1'b0);
        repeat (6)
        begin
            burst(4'($urandom), 1'b1, 1'b0);
            burst(4'($urandom), 1'b0, 1'b0);
        end
        set_ctrl(32'h20);
        chk_term(dbcsc_pkg::DBCSC_TERM_LOW);
        set_ctrl(32'h60);
        chk_term(dbcsc_pkg::DBCSC_TERM_HIGH);
        burst(4'h3, 1'b0, 1'b0);
        set_ctrl(32'h0);
        chk_term(dbcsc_pkg::DBCSC_TERM_FLOAT);
        set_ctrl(32'h8);
        burst(4'h5, 1'b1, 1'b0);
        burst(4'h4, 1'b0, 1'b0);
        set_ctrl(32'h0);
        set_ctrl(32'h4);
        burst(4'h9, 1'b0, 1'b0);
        apb(1'b1, 8'h00, 32'h10);
        repeat (10) @(posedge clk_sys);
        rd(8'h08, 33'h0_0000_0008);
        set_ctrl(32'h0);
        burst(4'h1, 1'b0, 1'b0);
        end_sim();
    end
endmodule // tb
`default_nettype wire
